/* File: src/cps_status.sv */
// Status and flag logic of the multimedia codec serial port: FIFO
// service requests, underrun/overrun errors, availability flags,
// codec command completion and the audio path enable flag.
// Assumes an outside FIFO datapath and framer on the same clock;
// software reaches the registers over APB.
//
// Operation
// - Audio tx request high at four or fewer entries, low at five up
// - Audio tx request interrupts unless its mask bit is cleared
// - Audio rx request high at six or more entries, low at five down
// - Audio rx request interrupts unless its mask bit is cleared
// - Telecom tx request as audio tx, with its own mask
// - Telecom rx request as audio rx, with its own mask
// - Fetch from empty audio tx FIFO sets unmaskable underrun bit
// - On audio underrun keep sending last sample until new data arrives
// - Audio sample into full rx FIFO dropped, overrun bit set
// - Telecom underrun as audio, last telecom sample repeated
// - Telecom sample into full rx FIFO dropped, overrun bit set
// - Audio tx not-full flag tracks a free entry, no interrupt
// - Audio rx not-empty flag tracks a valid entry, no interrupt
// - Telecom tx not-full flag tracks a free entry, no interrupt
// - Telecom rx not-empty flag tracks a valid entry, no interrupt
// - Write goes out, codec latches, echo returns next frame, done set
// - Read result returns in same frame, latched, read done set
// - Both done flags clear on any command data access
// - Audio enabled sets at sync after latched write of reg 8 bits
// - Audio enabled clears likewise when both bits written zero
// - Error bits sticky, write one clears, zero has no effect
// - Interrupt requests are levels following their source bits
// - Service requests read zero while the port is disabled
`timescale 1ns/100ps
`default_nettype none
`include "cps_consts.svh"

module cps_status
  import cps_pkg::*;
#(
  parameter int DEPTH    = `CPS_FIFO_DEPTH,
  parameter int SAMPLE_W = `CPS_SAMPLE_W,
  parameter int LVL_W    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // FIFO fill levels
  input  wire logic [LVL_W-1:0]    audio_tx_level,
  input  wire logic [LVL_W-1:0]    audio_rx_level,
  input  wire logic [LVL_W-1:0]    tel_tx_level,
  input  wire logic [LVL_W-1:0]    tel_rx_level,
  // Sample events from the framer
  input  wire logic                audio_tx_fetch,
  input  wire logic                audio_rx_push,
  input  wire logic                tel_tx_fetch,
  input  wire logic                tel_rx_push,
  // Transmit FIFO bottom entries and held samples
  input  wire logic [SAMPLE_W-1:0] audio_tx_bottom,
  input  wire logic [SAMPLE_W-1:0] tel_tx_bottom,
  output logic      [SAMPLE_W-1:0] audio_tx_sample,
  output logic      [SAMPLE_W-1:0] tel_tx_sample,
  // Receive FIFO write strobes, one cycle after the push
  output logic                     audio_rx_accept,
  output logic                     tel_rx_accept,
  // Codec command link
  input  wire logic                serial_frame_sync,
  input  wire logic                codec_latch,
  input  wire logic                reply_valid,
  input  wire logic [3:0]          reply_addr,
  input  wire logic [15:0]         reply_data,
  output logic      [20:0]         codec_cmd,
  // Port interrupt
  output logic                     irq
);

  // Parameter checks
  if (DEPTH < `CPS_RX_SVC_MIN + 1) begin : g_chk_depth
    $error("cps_status: DEPTH too small for thresholds");
  end
  if (LVL_W < $clog2(DEPTH + 1)) begin : g_chk_lvl
    $error("cps_status: LVL_W cannot hold DEPTH");
  end

  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] LVL_TXS  = LVL_W'(`CPS_TX_SVC_MAX);
  localparam logic [LVL_W-1:0] LVL_RXS  = LVL_W'(`CPS_RX_SVC_MIN);

  // Registers
  logic [`CPS_CTRL_W-1:0] ctrl_q;
  logic [3:0]             svc_q;
  logic [3:0]             err_q;
  logic [3:0]             avail_q;
  logic                   wr_done_q;
  logic                   rd_done_q;
  logic                   aud_en_q;
  logic [20:0]            cmd_q;
  logic                   cmd_new_q;
  logic [20:0]            cur_q;
  logic [3:0]             ret_addr_q;
  logic [15:0]            ret_data_q;
  cps_cmd_state_t         cst_q;
  cps_cmd_state_t         cst_d;

  // Channel vectors: 0 audio tx, 1 audio rx, 2 tel tx, 3 tel rx
  logic [LVL_W-1:0] lvl [4];
  logic [3:0]       evt;
  logic [3:0]       svc_d;
  logic [3:0]       avail_d;
  logic [3:0]       err_set;

  assign lvl[0] = audio_tx_level;
  assign lvl[1] = audio_rx_level;
  assign lvl[2] = tel_tx_level;
  assign lvl[3] = tel_rx_level;
  assign evt    = {tel_rx_push, tel_tx_fetch, audio_rx_push,
                   audio_tx_fetch};

  // Bus decode
  logic       port_en;
  logic [3:0] req_mask;
  logic       setup;
  logic       acc;
  logic       wr_acc;
  logic       hit_ctrl;
  logic       hit_data;
  logic       hit_stat;
  logic [31:0] status_word;
  logic [31:0] data_word;

  assign port_en  = ctrl_q[`CPS_CTRL_EN];
  assign req_mask = ctrl_q[`CPS_CTRL_MASK_LO +: 4];
  assign setup    = psel & ~penable;
  assign acc      = psel & penable & pready;
  assign wr_acc   = acc & pwrite;
  assign hit_ctrl = (paddr == `CPS_OFF_CTRL);
  assign hit_data = (paddr == `CPS_OFF_DATA);
  assign hit_stat = (paddr == `CPS_OFF_STATUS);

  // Per-channel thresholds and error events
  for (genvar i = 0; i < 4; i++) begin : g_chan
    if (i % 2 == 0) begin : g_tx
      // Transmit side: service at low fill, underrun on empty fetch
      assign svc_d[i]   = port_en & (lvl[i] <= LVL_TXS);
      assign avail_d[i] = (lvl[i] != LVL_FULL);
      assign err_set[i] = evt[i] & (lvl[i] == '0);
    end else begin : g_rx
      // Receive side: service at high fill, overrun on full push
      assign svc_d[i]   = port_en & (lvl[i] >= LVL_RXS);
      assign avail_d[i] = (lvl[i] != '0);
      assign err_set[i] = evt[i] & (lvl[i] == LVL_FULL);
    end
  end

  // Service request and availability flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_q   <= 4'h0;
      avail_q <= `CPS_AVAIL_RST;
    end else begin
      svc_q   <= svc_d;
      avail_q <= avail_d;
    end
  end

  // Sticky error bits, a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_q & ~((wr_acc & hit_stat) ?
                pwdata[`CPS_ST_ERR_LO +: 4] : 4'h0))
               | err_set;
    end
  end

  // Held transmit samples repeat through an underrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_tx_sample <= '0;
      tel_tx_sample   <= '0;
    end else begin
      if (audio_tx_fetch && audio_tx_level != '0) begin
        audio_tx_sample <= audio_tx_bottom;
      end
      if (tel_tx_fetch && tel_tx_level != '0) begin
        tel_tx_sample <= tel_tx_bottom;
      end
    end
  end

  // Receive write strobes, suppressed when full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_rx_accept <= 1'b0;
      tel_rx_accept   <= 1'b0;
    end else begin
      audio_rx_accept <= audio_rx_push & ~err_set[1];
      tel_rx_accept   <= tel_rx_push & ~err_set[3];
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CPS_CTRL_RST;
    end else if (wr_acc && hit_ctrl) begin
      ctrl_q <= pwdata[`CPS_CTRL_W-1:0];
    end
  end

  // Command written by software, taken by the framer at sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q     <= '0;
      cmd_new_q <= 1'b0;
    end else if (wr_acc && hit_data) begin
      cmd_q     <= pwdata[`CPS_ADDR_HI:0];
      cmd_new_q <= 1'b1;
    end else if (serial_frame_sync) begin
      cmd_new_q <= 1'b0;
    end
  end

  // Command sequence across frames
  always_comb begin
    cst_d = cst_q;
    case (cst_q)
      CMD_IDLE: begin
        cst_d = cst_q;
      end
      CMD_RD_SENT: begin
        cst_d = cst_q;
      end
      CMD_WR_SENT: begin
        if (codec_latch) begin
          cst_d = CMD_WR_LATCHED;
        end
      end
      CMD_WR_LATCHED: begin
        if (reply_valid) begin
          cst_d = CMD_WR_SENT;
        end
      end
      default: begin
        cst_d = CMD_IDLE;
      end
    endcase
    if (serial_frame_sync && cmd_new_q) begin
      cst_d = cmd_q[`CPS_RW_BIT] ? CMD_WR_SENT : CMD_RD_SENT;
    end
  end

  // State and the command now on the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_q <= CMD_IDLE;
      cur_q <= '0;
    end else begin
      cst_q <= cst_d;
      if (serial_frame_sync && cmd_new_q) begin
        cur_q <= cmd_q;
      end
    end
  end

  // Returned address and data latched from subframe 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_addr_q <= 4'h0;
      ret_data_q <= 16'h0000;
    end else if (reply_valid &&
                 (cst_q == CMD_RD_SENT || cst_q == CMD_WR_LATCHED)) begin
      ret_addr_q <= reply_addr;
      ret_data_q <= reply_data;
    end
  end

  // Completion flags, set wins over the clear by access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_done_q <= 1'b0;
      rd_done_q <= 1'b0;
    end else begin
      if (acc && hit_data) begin
        wr_done_q <= 1'b0;
        rd_done_q <= 1'b0;
      end
      if (reply_valid && cst_q == CMD_WR_LATCHED) begin
        wr_done_q <= 1'b1;
      end
      if (reply_valid && cst_q == CMD_RD_SENT) begin
        rd_done_q <= 1'b1;
      end
    end
  end

  // Audio path enable follows a latched write to the audio register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aud_en_q <= 1'b0;
    end else if (serial_frame_sync && cst_q == CMD_WR_LATCHED &&
                 cur_q[`CPS_ADDR_HI:`CPS_ADDR_LO] == `CPS_AUD_REG) begin
      aud_en_q <= cur_q[`CPS_AUD_IN_BIT] |
                  cur_q[`CPS_AUD_OUT_BIT];
    end
  end

  // Command word for the framer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      codec_cmd <= '0;
    end else begin
      codec_cmd <= cmd_q;
    end
  end

  // Merged level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(svc_q & req_mask)) |
             (|err_q);
    end
  end

  // Status word as software sees it, fields at their positions
  always_comb begin
    status_word                        = 32'h0000_0000;
    status_word[`CPS_ST_SVC_LO +: 4]   = svc_q;
    status_word[`CPS_ST_ERR_LO +: 4]   = err_q;
    status_word[`CPS_ST_AVAIL_LO +: 4] = avail_q;
    status_word[`CPS_ST_WR_DONE]       = wr_done_q;
    status_word[`CPS_ST_RD_DONE]       = rd_done_q;
    status_word[`CPS_ST_AUD_EN]        = aud_en_q;
  end

  // Command data word: returned address and data, access bit reads 0
  always_comb begin
    data_word                            = 32'h0000_0000;
    data_word[`CPS_ADDR_HI:`CPS_ADDR_LO] = ret_addr_q;
    data_word[`CPS_DATA_HI:`CPS_DATA_LO] = ret_data_q;
  end

  // APB answer: zero wait states, unmapped address errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~(hit_ctrl | hit_data | hit_stat);
      if (setup && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= 32'(ctrl_q);
        end else if (hit_data) begin
          prdata <= data_word;
        end else if (hit_stat) begin
          prdata <= status_word;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : cps_status
`default_nettype wire

/* File: src/cps_consts.svh */
// Constants of the codec port status block: offsets, field
// positions, reset values and FIFO thresholds.
// Assumes inclusion by bare name from package and design files.
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// Register byte offsets within the port window
`define CPS_OFF_CTRL      8'h00
`define CPS_OFF_DATA      8'h10
`define CPS_OFF_STATUS    8'h18

// Control register fields
`define CPS_CTRL_EN       0
`define CPS_CTRL_MASK_LO  1
`define CPS_CTRL_W        5
`define CPS_CTRL_RST      5'h00

// Command data register fields
`define CPS_DATA_LO       0
`define CPS_DATA_HI       15
`define CPS_RW_BIT        16
`define CPS_ADDR_LO       17
`define CPS_ADDR_HI       20

// Status register fields
`define CPS_ST_SVC_LO     0
`define CPS_ST_ERR_LO     4
`define CPS_ST_AVAIL_LO   8
`define CPS_ST_WR_DONE    12
`define CPS_ST_RD_DONE    13
`define CPS_ST_AUD_EN     14
`define CPS_ST_W          15
// Not-full flags set, not-empty flags clear while levels read zero
`define CPS_AVAIL_RST     4'h5

// Codec audio control register and its path enables
`define CPS_AUD_REG       4'h8
`define CPS_AUD_IN_BIT    14
`define CPS_AUD_OUT_BIT   15

// FIFO thresholds for service requests
`define CPS_TX_SVC_MAX    4
`define CPS_RX_SVC_MIN    6
`define CPS_FIFO_DEPTH    8
`define CPS_SAMPLE_W      16

`endif

/* File: src/cps_pkg.sv */
// Types shared by the codec port status block.
// Assumes the constants header sits beside this file.
`include "cps_consts.svh"

package cps_pkg;

  // Progress of the command repeated every serial frame
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_RD_SENT,
    CMD_WR_SENT,
    CMD_WR_LATCHED
  } cps_cmd_state_t;

endpackage : cps_pkg

/* File: sim/cps_status_chk.sv */
// Checker of the codec port status block: bus timing, error
// interrupts, held samples and dropped receive samples.
// Sees only the block's ports; bound to every instance below.
`timescale 1ns/100ps
`default_nettype none
module cps_status_chk #(
  parameter int DEPTH    = 8,
  parameter int SAMPLE_W = 16,
  parameter int LVL_W    = 4
) (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Bus handshake
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // FIFO side
  input wire logic [LVL_W-1:0]    audio_tx_level,
  input wire logic [LVL_W-1:0]    audio_rx_level,
  input wire logic [LVL_W-1:0]    tel_tx_level,
  input wire logic [LVL_W-1:0]    tel_rx_level,
  input wire logic                audio_tx_fetch,
  input wire logic                audio_rx_push,
  input wire logic                tel_tx_fetch,
  input wire logic                tel_rx_push,
  input wire logic [SAMPLE_W-1:0] audio_tx_bottom,
  input wire logic [SAMPLE_W-1:0] audio_tx_sample,
  input wire logic                audio_rx_accept,
  input wire logic                tel_rx_accept,
  // Port interrupt
  input wire logic                irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Zero wait states, errors only with the answer
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Underruns reach the interrupt two edges on, whatever the masks
  a_aud_under_irq: assert property (
    audio_tx_fetch && audio_tx_level == 0 |-> ##2 irq)
    else $error("audio underrun gave no interrupt");
  a_tel_under_irq: assert property (
    tel_tx_fetch && tel_tx_level == 0 |-> ##2 irq)
    else $error("telecom underrun gave no interrupt");
  // Last sample held on underrun, bottom entry taken otherwise
  a_aud_hold: assert property (
    audio_tx_fetch && audio_tx_level == 0 |=> $stable(audio_tx_sample))
    else $error("audio sample changed on underrun");
  a_aud_load: assert property (
    audio_tx_fetch && audio_tx_level != 0
    |=> audio_tx_sample == $past(audio_tx_bottom))
    else $error("audio sample not taken from bottom");
  // Samples into a full receive FIFO are dropped
  a_aud_drop: assert property (
    audio_rx_push && audio_rx_level == DEPTH |=> !audio_rx_accept)
    else $error("audio sample accepted while full");
  a_aud_accept: assert property (
    audio_rx_push && audio_rx_level < DEPTH |=> audio_rx_accept)
    else $error("audio sample lost while not full");
  a_tel_drop: assert property (
    tel_rx_push && tel_rx_level == DEPTH |=> !tel_rx_accept)
    else $error("telecom sample accepted while full");
  a_tel_accept: assert property (
    tel_rx_push && tel_rx_level < DEPTH |=> tel_rx_accept)
    else $error("telecom sample lost while not full");
endmodule : cps_status_chk

bind cps_status cps_status_chk #(
  .DEPTH(DEPTH), .SAMPLE_W(SAMPLE_W), .LVL_W(LVL_W)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr),
  .audio_tx_level(audio_tx_level), .audio_rx_level(audio_rx_level),
  .tel_tx_level(tel_tx_level), .tel_rx_level(tel_rx_level),
  .audio_tx_fetch(audio_tx_fetch), .audio_rx_push(audio_rx_push),
  .tel_tx_fetch(tel_tx_fetch), .tel_rx_push(tel_rx_push),
  .audio_tx_bottom(audio_tx_bottom), .audio_tx_sample(audio_tx_sample),
  .audio_rx_accept(audio_rx_accept), .tel_rx_accept(tel_rx_accept),
  .irq(irq));
`default_nettype wire

/* File: sim/cps_codec_model.sv */
// Behavioural model of the external codec on the frame link.
// Frames of FR cycles: sync, one reply in subframe 0, write latch.
`timescale 1ns/100ps
`default_nettype none
module cps_codec_model #(
  parameter int FR = 24
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Command from the port
  input  wire logic [20:0] codec_cmd,
  // Frame link back to the port
  output logic             serial_frame_sync,
  output logic             codec_latch,
  output logic             reply_valid,
  output logic      [3:0]  reply_addr,
  output logic      [15:0] reply_data
);
  logic [15:0] regs_q [16];
  logic [20:0] cmd_q;
  logic [19:0] echo_q;
  logic [19:0] val_q;
  logic [7:0]  cnt_q;

  // Released reply lines show the inverse of the last value
  assign reply_addr = reply_valid ? val_q[19:16] : ~val_q[19:16];
  assign reply_data = reply_valid ? val_q[15:0] : ~val_q[15:0];

  // Frame counter, command capture, reply and write latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      cmd_q <= '0;
      echo_q <= '0;
      val_q <= '0;
      serial_frame_sync <= 1'b0;
      codec_latch <= 1'b0;
      reply_valid <= 1'b0;
      foreach (regs_q[i]) regs_q[i] <= '0;
    end else begin
      cnt_q <= (cnt_q == 8'(FR - 1)) ? 8'h00 : cnt_q + 8'h01;
      serial_frame_sync <= cnt_q == 8'(FR - 1);
      if (cnt_q == 8'h01)
        cmd_q <= codec_cmd; // Command as the port sent it
      reply_valid <= cnt_q == 8'h03;
      if (cnt_q == 8'h03)
        val_q <= cmd_q[16] ? echo_q
                 : {cmd_q[20:17], regs_q[cmd_q[20:17]]};
      codec_latch <= cnt_q == 8'h07 && cmd_q[16];
      if (cnt_q == 8'h07 && cmd_q[16]) begin
        regs_q[cmd_q[20:17]] <= cmd_q[15:0];
        echo_q <= {cmd_q[20:17], cmd_q[15:0]};
      end
    end
  end
endmodule : cps_codec_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the codec port status block.
// Drives the bus and FIFO side; the codec model closes the link.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, err, en;
  logic        aacc, tacc, sync, latch, rvld, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic        pready, pslverr;
  logic [3:0]  lv [4];
  logic [3:0]  evt, raddr;
  logic [4:0]  ctl;
  logic [11:0] f;
  logic [15:0] bot, v, atx_s, ttx_s, rdata;
  logic [20:0] cmd;
  int          fails, checked, seed, i, k;

  cps_status dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .audio_tx_level(lv[0]), .audio_rx_level(lv[1]),
    .tel_tx_level(lv[2]), .tel_rx_level(lv[3]),
    .audio_tx_fetch(evt[0]), .audio_rx_push(evt[1]),
    .tel_tx_fetch(evt[2]), .tel_rx_push(evt[3]),
    .audio_tx_bottom(bot), .tel_tx_bottom(bot),
    .audio_tx_sample(atx_s), .tel_tx_sample(ttx_s),
    .audio_rx_accept(aacc), .tel_rx_accept(tacc),
    .serial_frame_sync(sync), .codec_latch(latch), .reply_valid(rvld),
    .reply_addr(raddr), .reply_data(rdata), .codec_cmd(cmd), .irq(irq));
  cps_codec_model codec (
    .pclk(pclk), .presetn(presetn), .codec_cmd(cmd),
    .serial_frame_sync(sync), .codec_latch(latch), .reply_valid(rvld),
    .reply_addr(raddr), .reply_data(rdata));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One bus transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll the status word until bit b is set
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h18, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 60);
    chk("status wait", 32'h1, {31'h0, rd[b]});
  endtask : wait_st

  // One event pulse, then let status and interrupt settle
  task automatic pulse(input int q);
    @(posedge pclk);
    evt[q] <= 1'b1;
    @(posedge pclk);
    evt[q] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  // Expected flags of the status word from levels and enable
  function automatic logic [11:0] exp_flags(input logic e);
    logic [11:0] x;
    x = '0;
    x[0] = e & (lv[0] <= 4);
    x[1] = e & (lv[1] >= 6);
    x[2] = e & (lv[2] <= 4);
    x[3] = e & (lv[3] >= 6);
    x[8] = lv[0] != 8;
    x[9] = lv[1] != 0;
    x[10] = lv[2] != 8;
    x[11] = lv[3] != 0;
    return x;
  endfunction : exp_flags

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("[ERR] watchdog expired");
    finish_test();
  end

  initial begin
    seed = 51990;
    presetn <= 1'b0;
    {psel, penable, pwrite, evt, paddr, pwdata, bot} <= '0;
    foreach (lv[q]) lv[q] <= 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk("status reset", 32'h500, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    // Level sweep 0..8, then random levels, masks and enable
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      for (k = 0; k < 4; k++)
        lv[k] <= (i < 9) ? 4'(i) : 4'(r[8*k +: 8] % 9);
      r = $random(seed);
      ctl = {r[4:1], r[0] | (i < 9)};
      apb(1'b1, 8'h00, {27'h0, ctl});
      apb(1'b0, 8'h18, 32'h0);
      f = exp_flags(ctl[0]);
      chk("flags", {20'h0, f}, rd);
      chk("irq svc", {31'h0, |(f[3:0] & ctl[4:1])}, {31'h0, irq});
    end
    $display("test levels done");
    // Underrun and overrun per FIFO with port off, masks clear
    apb(1'b1, 8'h00, 32'h0);
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      v = r[15:0];
      bot <= v;
      lv[k] <= k[0] ? 4'h3 : 4'h2;
      pulse(k);
      lv[k] <= k[0] ? 4'h8 : 4'h0;
      bot <= ~v;
      pulse(k);
      if (!k[0])
        chk("held", {16'h0, v}, {16'h0, k == 0 ? atx_s : ttx_s});
      chk("irq err", 32'h1, {31'h0, irq});
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("err set", 32'(1 << k), {28'h0, rd[7:4]});
      apb(1'b1, 8'h18, 32'(1 << (k + 4)));
      apb(1'b0, 8'h18, 32'h0);
      chk("err clr", 32'h0, {28'h0, rd[7:4]});
      chk("irq clr", 32'h0, {31'h0, irq});
    end
    $display("test errors done");
    // Codec writes to the audio control register and to register 3, then read back
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      v = (k == 0) ? 16'h4000 : (k == 1) ? 16'h8000 : 16'h0000;
      if (k == 3)
        v = r[15:0];
      apb(1'b1, 8'h10, {11'h0, k == 3 ? 4'h3 : 4'h8, 1'b1, v});
      wait_st(12);
      if (k < 3)
        chk("aud en", {31'h0, |v[15:14]}, {31'h0, rd[14]});
      if (k == 3)
        apb(1'b1, 8'h10, {11'h0, 4'h3, 17'h0});
      if (k == 3)
        wait_st(13);
      apb(1'b0, 8'h10, 32'h0);
      chk("cmd data", {11'h0, k == 3 ? 4'h3 : 4'h8, 1'b0, v}, rd);
      apb(1'b0, 8'h18, 32'h0);
      chk("done clr", 32'h0, {30'h0, rd[13:12]});
    end
    $display("test codec done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
